/* File: rtl/mseq_pkg.sv */
// Shared constants and types for the microprogram sequencer.
package mseq_pkg;
	// Microword layout: positions 0..87, eleven bytes, only 82 positions stored.
	localparam int WORD_BITS = 88;
	localparam int WORD_BYTES = 11;
	localparam int DATA_BITS = 82;
	localparam int ADDR_BITS = 13;
	localparam int STORE_WORDS = 8192;
	localparam int CTL_BITS = 64;
	localparam int SEL_LSB = 64;
	localparam int SAVE_BIT = 68;
	localparam int BRANCH_LSB = 71;
	localparam int BRANCH_BITS = 13;
	localparam int PAGE_LSB = 76;
	localparam int NI_BITS = 12;
	localparam int HOLD_PAR_BITS = 10;

	// Timing: one microword cycle at the processor clock.
	localparam int CLK_PERIOD_PS = 8000;
	localparam int MICRO_CYCLE_NS = 100;
	localparam int MICRO_CYCLE_CLKS = (MICRO_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Register byte offsets on the maintenance bus.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA0 = 8'h08;
	localparam logic [7:0] OFS_WDATA1 = 8'h0C;
	localparam logic [7:0] OFS_WDATA2 = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_RDATA0 = 8'h18;
	localparam logic [7:0] OFS_RDATA1 = 8'h1C;
	localparam logic [7:0] OFS_RDATA2 = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	// Field positions inside those registers.
	localparam int CTRL_RUN = 0;
	localparam int CTRL_MAINT = 1;
	localparam int CMD_WRITE = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_START = 2;
	localparam int STAT_PERR = 0;
	localparam int STAT_RUN = 1;
	localparam int STAT_S_LSB = 16;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// Trap entry address is not fixed by the hardware; default is arbitrary.
	localparam logic [12:0] TRAP_ENTRY_DEFAULT = 13'h0010;

	typedef enum logic [2:0] {
		SM_BRANCH_ADD = 3'b000,
		SM_BRANCH_FULL = 3'b001,
		SM_RET_FIRST = 3'b010,
		SM_RET_SECOND = 3'b011,
		SM_PAGE = 3'b100,
		SM_NEXT_INSTR = 3'b101,
		SM_MAINT = 3'b110,
		SM_TRAP = 3'b111
	} mseq_smux_t;

	typedef enum logic [1:0] {
		RM_COPY_ROM = 2'b00,
		RM_AD_SHIFT = 2'b01,
		RM_AD = 2'b10,
		RM_FP_ROM = 2'b11
	} mseq_rmux_t;

	typedef enum logic [1:0] {
		ST_MAINT = 2'b00,
		ST_RUN = 2'b01
	} mseq_state_t;
endpackage

/* File: rtl/mseq_sequencer.sv */
// Writable microprogram store with next-microword address sequencer.
`timescale 1ns/1ps

// Operation
// - Store word: 82 data bits plus one odd parity bit per byte.
// - Data splits into 64-bit control field and 18-bit address select field.
// - Positions 69, 70, 84 and up have no storage and read zero.
// - One store of 8K microwords with 13-bit address.
// - One microword cycle lasts 13 clocks, 104 ns; fetched word lands in holding register.
// - Holding register keeps 77 data bits and 10 parity bits until replaced.
// - Sequence address register holds address and increments for plus-one.
// - Selection logic steers sequence address except during maintenance loading.
// - Code 0 joins branch bits 71-75 with page adder, for codes A-F.
// - Code 1 takes full branch address bits 71-83 for codes 1 and 4.
// - Codes 2 and 3 return to first or conditionally second return register.
// - Code 4 joins sequence bits 8-12 with bits 76-83 for 6, 7.
// - Code 5 takes 12-bit next-instruction address for selection code 5.
// - Code 6 takes 13 maintenance bits for start, load or test.
// - Code 7 supplies the trap entry address.
// - Bit 68 loads first return register with plus-one one clock later.
// - Second return register strobes with the sequence address when enabled.
// - Selection logic decodes bits 64-67 with conditions and trap controls.
// - Eight-bit adder adds offset source to bits 76-83 for page offset.
// - Offset source: copy ROM, shifted byte, unshifted byte, floating ROM.
// - Register byte plus branch upper bits uses the unshifted byte.
module mseq_sequencer import mseq_pkg::*; #(
	parameter logic [12:0] TRAP_ENTRY = TRAP_ENTRY_DEFAULT
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Maintenance register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Execution unit side.
	input wire logic branch_cond,
	input wire logic trap_req,
	input wire logic [11:0] next_instr_addr,
	input wire logic [7:0] reg_file_byte,
	output logic [63:0] exec_ctl,
	output logic [9:0] exec_ctl_par,
	output logic [12:0] micro_addr,
	output logic micro_step
);
	localparam logic [3:0] CYC_LAST = 4'(MICRO_CYCLE_CLKS - 1);

	// Store, holding register and sequencing state.
	logic [DATA_BITS+WORD_BYTES-1:0] store_mem [0:STORE_WORDS-1];
	logic [WORD_BITS-1:0] rd_word;
	logic [WORD_BITS-1:0] wr_word;
	logic [WORD_BYTES-1:0] wr_par;
	logic [WORD_BYTES-1:0] rd_bad;
	logic [63:0] hold_ctl_q;
	logic [12:0] hold_bra_q;
	logic [9:0] hold_par_q;
	logic [4:0] sel_field_q;
	logic [12:0] s_q;
	logic [12:0] s_copy_q;
	logic [12:0] ret_first_q;
	logic [12:0] ret_second_q;
	logic save_dly_q;
	logic [3:0] cyc_q;
	logic fetch_q;
	mseq_state_t state_q;
	// Maintenance registers.
	logic [1:0] ctrl_q;
	logic [31:0] wdata0_q;
	logic [31:0] wdata1_q;
	logic [23:0] wdata2_q;
	logic [31:0] rdata0_q;
	logic [31:0] rdata1_q;
	logic [23:0] rdata2_q;
	logic perr_q;
	logic [31:0] prdata_q;
	// Decode results.
	logic step;
	logic wr_acc;
	logic rd_setup;
	logic mapped;
	logic cmd_wr;
	logic cmd_rd;
	logic cmd_start;
	logic maddr_wr;
	logic take_branch;
	logic ret2_strobe;
	logic [12:0] rd_bra;
	logic [12:0] next_addr;
	mseq_smux_t smux;
	mseq_rmux_t rmux;
	logic [7:0] rmux_out;
	logic [7:0] radd;
	logic [7:0] copy_rom;
	logic [7:0] fp_rom;

	// Unstored positions are forced to zero on every read of the store.
	function automatic logic [WORD_BITS-1:0] unpack(input logic [DATA_BITS-1:0] d);
		logic [WORD_BITS-1:0] w;
		w = '0;
		w[68:0] = d[68:0];
		w[83:71] = d[81:69];
		return w;
	endfunction

	// Each store entry: eleven parity bits above 82 packed data bits.
	assign wr_word = {4'h0, wdata2_q[19:7], 2'h0, wdata2_q[4:0], wdata1_q, wdata0_q};
	assign rd_word = unpack(store_mem[s_q][DATA_BITS-1:0]);

	genvar gb;
	generate
		for (gb = 0; gb < WORD_BYTES; gb++) begin : g_par
			assign wr_par[gb] = ~^wr_word[gb*8 +: 8];
			assign rd_bad[gb] = ~^{store_mem[s_q][DATA_BITS+gb], rd_word[gb*8 +: 8]};
		end
	endgenerate

	// Position 71 is the branch address MSB, so the field is reversed on the way in.
	genvar gr;
	generate
		for (gr = 0; gr < BRANCH_BITS; gr++) begin : g_bra
			assign rd_bra[BRANCH_BITS-1-gr] = rd_word[BRANCH_LSB+gr];
		end
	endgenerate

	// Bus decode; the slave answers with zero wait states.
	assign wr_acc = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign mapped = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'h0);
	assign cmd_wr = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_WRITE];
	assign cmd_rd = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_READ];
	assign cmd_start = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_START];
	assign maddr_wr = wr_acc && (paddr == OFS_MADDR);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
			wdata0_q <= 32'h0000_0000;
			wdata1_q <= 32'h0000_0000;
			wdata2_q <= 24'h00_0000;
		end else if (wr_acc) begin
			case (paddr)
				OFS_CTRL: ctrl_q <= pwdata[1:0];
				OFS_WDATA0: wdata0_q <= pwdata;
				OFS_WDATA1: wdata1_q <= pwdata;
				OFS_WDATA2: wdata2_q <= pwdata[23:0];
				default: ctrl_q <= ctrl_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (paddr)
				OFS_CTRL: prdata_q <= {30'h0, ctrl_q};
				OFS_MADDR: prdata_q <= {19'h0, s_q};
				OFS_WDATA0: prdata_q <= wdata0_q;
				OFS_WDATA1: prdata_q <= wdata1_q;
				OFS_WDATA2: prdata_q <= {8'h00, wdata2_q};
				OFS_RDATA0: prdata_q <= rdata0_q;
				OFS_RDATA1: prdata_q <= rdata1_q;
				OFS_RDATA2: prdata_q <= {8'h00, rdata2_q};
				OFS_STATUS: prdata_q <= {3'h0, s_q, 14'h0, (state_q == ST_RUN), perr_q};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Run state: maintenance mode stops the sequencer so the store can be loaded.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_MAINT;
		end else begin
			case (state_q)
				ST_MAINT: if (cmd_start || (ctrl_q[CTRL_RUN] && !ctrl_q[CTRL_MAINT])) begin
					state_q <= ST_RUN;
				end
				ST_RUN: if (ctrl_q[CTRL_MAINT] || !ctrl_q[CTRL_RUN]) begin
					state_q <= ST_MAINT;
				end
				default: state_q <= ST_MAINT;
			endcase
		end
	end

	// Microword cycle timer; the step edge closes each 13-clock, 104 ns cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_q <= 4'h0;
		end else if (state_q != ST_RUN || cyc_q == CYC_LAST) begin
			cyc_q <= 4'h0;
		end else begin
			cyc_q <= cyc_q + 4'h1;
		end
	end
	assign step = (state_q == ST_RUN) && (cyc_q == CYC_LAST);
	assign micro_step = step;

	// Fixed lookup tables; the offsets spread entries four and two words apart.
	assign copy_rom = {2'h0, reg_file_byte[3:0], 2'h0};
	assign fp_rom = {3'h2, reg_file_byte[3:0], 1'b0};

	always_comb begin
		case (rmux)
			RM_COPY_ROM: rmux_out = copy_rom;
			RM_AD_SHIFT: rmux_out = {reg_file_byte[6:0], 1'b0};
			RM_AD: rmux_out = reg_file_byte;
			RM_FP_ROM: rmux_out = fp_rom;
			default: rmux_out = reg_file_byte;
		endcase
	end
	assign radd = rmux_out + hold_bra_q[7:0];

	// Address selection: trap first, then the decoded selection code.
	always_comb begin
		smux = SM_BRANCH_FULL;
		rmux = RM_AD;
		take_branch = 1'b1;
		ret2_strobe = 1'b0;
		case (sel_field_q[3:0])
			4'h1: smux = SM_BRANCH_FULL;
			4'h2: smux = SM_RET_FIRST;
			4'h3: begin
				smux = SM_RET_SECOND;
				take_branch = branch_cond;
			end
			4'h4: begin
				smux = SM_BRANCH_FULL;
				ret2_strobe = 1'b1;
			end
			4'h5: smux = SM_NEXT_INSTR;
			4'h6: smux = SM_PAGE;
			4'h7: begin
				smux = SM_PAGE;
				take_branch = branch_cond;
			end
			4'hA: begin
				smux = SM_BRANCH_ADD;
				rmux = RM_AD;
			end
			4'hB: begin
				smux = SM_BRANCH_ADD;
				rmux = RM_AD_SHIFT;
			end
			4'hC: begin
				smux = SM_BRANCH_ADD;
				rmux = RM_COPY_ROM;
			end
			4'hD: begin
				smux = SM_BRANCH_ADD;
				rmux = RM_FP_ROM;
			end
			4'hE: begin
				smux = SM_BRANCH_ADD;
				rmux = RM_AD;
				take_branch = branch_cond;
			end
			4'hF: begin
				smux = SM_BRANCH_ADD;
				rmux = RM_AD_SHIFT;
				take_branch = branch_cond;
			end
			default: take_branch = 1'b0;
		endcase
		if (trap_req) begin
			smux = SM_TRAP;
			take_branch = 1'b1;
			ret2_strobe = 1'b0;
		end
	end

	always_comb begin
		case (smux)
			SM_BRANCH_ADD: next_addr = {hold_bra_q[12:8], radd};
			SM_BRANCH_FULL: next_addr = hold_bra_q;
			SM_RET_FIRST: next_addr = ret_first_q;
			SM_RET_SECOND: next_addr = ret_second_q;
			SM_PAGE: next_addr = {s_q[12:8], hold_bra_q[7:0]};
			SM_NEXT_INSTR: next_addr = {1'b0, next_instr_addr};
			SM_TRAP: next_addr = TRAP_ENTRY;
			default: next_addr = pwdata[12:0];
		endcase
		if (!take_branch) begin
			next_addr = s_q + 13'h1;
		end
	end

	// Sequence address: maintenance path owns it outside the run state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= 13'h0000;
		end else if (state_q == ST_MAINT) begin
			if (maddr_wr) begin
				s_q <= pwdata[12:0];
			end else if (cmd_wr || cmd_rd) begin
				s_q <= s_q + 13'h1;
			end
		end else if (step) begin
			s_q <= next_addr;
		end
	end

	// The plus-one copy lets the first return register load a clock late.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_copy_q <= 13'h0000;
			save_dly_q <= 1'b0;
			ret_first_q <= 13'h0000;
			ret_second_q <= 13'h0000;
		end else begin
			save_dly_q <= step && sel_field_q[SAVE_BIT-SEL_LSB];
			if (step) begin
				s_copy_q <= s_q + 13'h1;
			end
			if (save_dly_q) begin
				ret_first_q <= s_copy_q;
			end
			if (step && ret2_strobe) begin
				ret_second_q <= s_q + 13'h1;
			end
		end
	end

	// Store write from the maintenance path; positions 69, 70 are dropped.
	always_ff @(posedge pclk) begin
		if (state_q == ST_MAINT && cmd_wr) begin
			store_mem[s_q] <= {wr_par, wr_word[83:71], wr_word[68:0]};
		end
	end

	// Fetch the new word one clock after the address strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_q <= 1'b0;
			hold_ctl_q <= 64'h0000_0000_0000_0000;
			hold_bra_q <= 13'h0000;
			hold_par_q <= 10'h000;
			sel_field_q <= 5'h00;
		end else begin
			fetch_q <= step || cmd_start;
			if (fetch_q) begin
				hold_ctl_q <= rd_word[CTL_BITS-1:0];
				hold_bra_q <= rd_bra;
				hold_par_q <= {store_mem[s_q][DATA_BITS+10 -: 2],
					store_mem[s_q][DATA_BITS +: 8]};
				sel_field_q <= rd_word[SEL_LSB +: 5];
			end
		end
	end
	assign exec_ctl = hold_ctl_q;
	assign exec_ctl_par = hold_par_q;
	assign micro_addr = s_q;

	// Maintenance readback and sticky parity error; a new error beats the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata0_q <= 32'h0000_0000;
			rdata1_q <= 32'h0000_0000;
			rdata2_q <= 24'h00_0000;
			perr_q <= 1'b0;
		end else begin
			if (state_q == ST_MAINT && cmd_rd) begin
				rdata0_q <= rd_word[31:0];
				rdata1_q <= rd_word[63:32];
				rdata2_q <= rd_word[87:64];
			end
			if ((fetch_q || (state_q == ST_MAINT && cmd_rd)) && (|rd_bad)) begin
				perr_q <= 1'b1;
			end else if (wr_acc && paddr == OFS_STATUS && pwdata[STAT_PERR]) begin
				perr_q <= 1'b0;
			end
		end
	end

	// Checks.
	// Clocks since the last step, saturating, so a long gap cannot wrap into a short one.
	logic [3:0] gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 4'hF;
		end else if (step) begin
			gap_q <= 4'h0;
		end else if (gap_q != 4'hF) begin
			gap_q <= gap_q + 4'h1;
		end
	end

	sequence s_step;
		step;
	endsequence

	a_cycle_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		s_step |-> gap_q >= CYC_LAST) else $error("microword cycle shorter than 100 ns");
	a_unstored_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rdata2_q[6:5] == 2'h0 && rdata2_q[23:20] == 4'h0) else $error("unstored bit not zero");
	a_plus_one: assert property (@(posedge pclk) disable iff (!presetn)
		step && !take_branch |=> s_q == $past(s_q) + 13'h1) else $error("increment missed");
	a_trap_entry: assert property (@(posedge pclk) disable iff (!presetn)
		step && trap_req |=> s_q == TRAP_ENTRY) else $error("trap entry not taken");
	a_first_return: assert property (@(posedge pclk) disable iff (!presetn)
		step && sel_field_q[4] |=> ##1 ret_first_q == $past(s_q, 2) + 13'h1)
		else $error("first return register not loaded one clock late");
	a_second_return: assert property (@(posedge pclk) disable iff (!presetn)
		step && ret2_strobe |=> ret_second_q == $past(s_q) + 13'h1)
		else $error("second return register not strobed with address");
	a_next_instr: assert property (@(posedge pclk) disable iff (!presetn)
		step && !trap_req && sel_field_q[3:0] == 4'h5 |=> s_q == {1'b0, $past(next_instr_addr)})
		else $error("next instruction address not taken");
	a_full_branch: assert property (@(posedge pclk) disable iff (!presetn)
		step && !trap_req && sel_field_q[3:0] == 4'h1 |=> s_q == $past(hold_bra_q))
		else $error("full branch address not taken");
	a_maint_owns: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == ST_MAINT && !maddr_wr && !cmd_wr && !cmd_rd |=> $stable(s_q))
		else $error("sequence address moved in maintenance without a command");
	a_unshifted_add: assert property (@(posedge pclk) disable iff (!presetn)
		sel_field_q[3:0] == 4'hA && !trap_req |-> radd == 8'(reg_file_byte + hold_bra_q[7:0]))
		else $error("page adder not using unshifted byte");
	a_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
		!fetch_q |=> $stable(hold_ctl_q)) else $error("holding register changed between fetches");
endmodule // mseq_sequencer

/* File: tb/mseq_exec_model.sv */
// Behavioural model of the execution units that feed the sequencer.
`timescale 1ns/1ps
module mseq_exec_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Values the bench asks the units to present.
	input wire logic want_cond,
	input wire logic want_trap,
	input wire logic [11:0] want_ni,
	input wire logic [7:0] want_byte,
	// Towards the sequencer.
	output logic branch_cond,
	output logic trap_req,
	output logic [11:0] next_instr_addr,
	output logic [7:0] reg_file_byte
);
	// Outputs are registered like real unit outputs, so a request lands one clock late.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			branch_cond <= 1'b0;
			trap_req <= 1'b0;
			next_instr_addr <= 12'h000;
			reg_file_byte <= 8'h00;
		end else begin
			branch_cond <= want_cond;
			trap_req <= want_trap;
			next_instr_addr <= want_ni;
			reg_file_byte <= want_byte;
		end
	end
endmodule // mseq_exec_model

/* File: tb/testbench.sv */
// Self-checking bench for the microprogram sequencer.
`timescale 1ns/1ps
module testbench import mseq_pkg::*;;
	localparam logic [12:0] TRAP_AT = 13'h0B0B;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, branch_cond, trap_req, micro_step;
	logic [11:0] next_instr_addr;
	logic [7:0] reg_file_byte;
	logic [63:0] exec_ctl;
	logic [9:0] exec_ctl_par;
	logic [12:0] micro_addr;
	logic want_cond = 1'b0;
	logic want_trap = 1'b0;
	logic [11:0] want_ni = 12'hABC;
	logic [7:0] want_byte = 8'h12;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [87:0] mem[int];
	logic [12:0] ta[19] = '{13'h0100, 13'h0101, 13'h0200, 13'h0300, 13'h0201, 13'h0202,
		13'h0301, 13'h0ABC, 13'h0A45, 13'h1512, 13'h1624, 13'h1708, 13'h1844, 13'h1845,
		13'h1912, 13'h1913, 13'h1914, 13'h1915, 13'h19F0};
	logic [3:0] ts[19] = '{4'h0, 4'h1, 4'h4, 4'h3, 4'h3, 4'h2, 4'h5, 4'h6, 4'hA, 4'hB,
		4'hC, 4'hD, 4'h7, 4'hE, 4'hF, 4'h8, 4'h9, 4'h7, 4'h0};
	logic [12:0] tbr[19] = '{13'h0, 13'h0200, 13'h0300, 13'h0, 13'h0, 13'h0, 13'h0,
		13'h0045, 13'h1500, 13'h1600, 13'h1700, 13'h1800, 13'h0011, 13'h1900, 13'h1A00,
		13'h0, 13'h0, 13'h00F0, 13'h0};
	logic tc[19] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 1, 0};
	logic [12:0] tn[19] = '{13'h0101, 13'h0200, 13'h0300, 13'h0201, 13'h0202, 13'h0301,
		13'h0ABC, 13'h0A45, 13'h1512, 13'h1624, 13'h1708, 13'h1844, 13'h1845, 13'h1912,
		13'h1913, 13'h1914, 13'h1915, 13'h19F0, TRAP_AT};

	mseq_sequencer #(.TRAP_ENTRY(TRAP_AT)) mseq_sequencer_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .branch_cond(branch_cond),
		.trap_req(trap_req), .next_instr_addr(next_instr_addr), .reg_file_byte(reg_file_byte),
		.exec_ctl(exec_ctl), .exec_ctl_par(exec_ctl_par), .micro_addr(micro_addr),
		.micro_step(micro_step));
	mseq_exec_model mseq_exec_model_inst (.pclk(pclk), .presetn(presetn), .want_cond(want_cond),
		.want_trap(want_trap), .want_ni(want_ni), .want_byte(want_byte),
		.branch_cond(branch_cond), .trap_req(trap_req), .next_instr_addr(next_instr_addr),
		.reg_file_byte(reg_file_byte));

	always #4 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Word image with a control field derived from its own address, so a wrong fetch shows.
	function automatic logic [87:0] mkw(logic [12:0] a, logic [3:0] s, logic sv, logic [12:0] b);
		logic [87:0] w;
		w = '0;
		w[63:0] = {a, 38'h2A_AAAA_AAAA, a};
		w[67:64] = s;
		w[68] = sv;
		for (int i = 0; i < 13; i++) w[71 + i] = b[12 - i];
		return w;
	endfunction

	function automatic logic [9:0] par(logic [87:0] w);
		logic [9:0] p;
		for (int k = 0; k < 8; k++) p[k] = ~^w[8 * k +: 8];
		p[8] = ~^w[79:72];
		p[9] = ~^w[87:80];
		return p;
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			print_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, msg);
	endtask

	task automatic load(input logic [12:0] a, input logic [87:0] w);
		mem[a] = w;
		wr(OFS_MADDR, {19'h0, a});
		wr(OFS_WDATA0, w[31:0]);
		wr(OFS_WDATA1, w[63:32]);
		wr(OFS_WDATA2, {8'h00, w[87:64]});
		wr(OFS_CMD, 32'h1);
	endtask

	task automatic test_reset();
		logic [31:0] r;
		logic e;
		chk(micro_addr, 13'h0, "address after reset");
		chk(exec_ctl, 64'h0, "holding after reset");
		rdc(OFS_CTRL, 32'h2, "control after reset");
		apb(1'b0, 8'h28, 32'h0, r, e);
		chk({e, r}, {1'b1, 32'h0}, "unmapped read");
		apb(1'b1, 8'h05, 32'h1, r, e);
		chk(e, 1'b1, "misaligned write");
		$display("test reset done");
	endtask

	task automatic test_store();
		load(13'h1FFF, '1);
		rdc(OFS_STATUS, 32'h0, "address wraps past top word");
		wr(OFS_MADDR, 32'h1FFF);
		wr(OFS_CMD, 32'h2);
		rdc(OFS_RDATA0, 32'hFFFF_FFFF, "readback low");
		rdc(OFS_RDATA1, 32'hFFFF_FFFF, "readback middle");
		rdc(OFS_RDATA2, 32'h000F_FF9F, "unstored positions read zero");
		rdc(OFS_STATUS, 32'h0, "no parity error after readback");
		$display("test store done");
	endtask

	task automatic test_run();
		int last, n;
		bit seen;
		for (int i = 0; i < 19; i++) load(ta[i], mkw(ta[i], ts[i], i == 3, tbr[i]));
		load(TRAP_AT, mkw(TRAP_AT, 4'h0, 1'b0, 13'h0));
		wr(OFS_MADDR, 32'h0100);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CMD, 32'h4);
		last = 0;
		for (int i = 0; i < 19; i++) begin
			@(posedge pclk);
			want_cond <= tc[i];
			want_trap <= (i == 18);
			n = 0;
			do begin
				@(posedge pclk);
				#1;
				n++;
			end while (micro_step !== 1'b1 && n < 40);
			if (n >= 40) begin
				errors++;
				print_verdict();
			end
			if (i == 0) chk(exec_ctl, mem[ta[0]][63:0], "first fetch");
			if (i > 0) chk(cyc - last, MICRO_CYCLE_CLKS, "step spacing");
			last = cyc;
			@(posedge pclk);
			#1;
			chk(micro_addr, tn[i], "next address");
			@(posedge pclk);
			#1;
			chk(exec_ctl, mem[tn[i]][63:0], "holding control");
			chk(exec_ctl_par, par(mem[tn[i]]), "holding parity");
		end
		@(posedge pclk);
		want_trap <= 1'b0;
		wr(OFS_CTRL, 32'h2);
		seen = 0;
		repeat (40) begin
			@(posedge pclk);
			#1;
			if (micro_step === 1'b1) seen = 1;
		end
		chk(seen, 1'b0, "no steps while loading");
		rdc(OFS_STATUS, {3'h0, TRAP_AT, 16'h0000}, "stopped at trap entry");
		$display("test run done");
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		test_reset();
		test_store();
		test_run();
		print_verdict();
	end
endmodule // testbench
